// *** rqd_request_path.v ***
// requester request path: descriptor to request header framer
`timescale 1ns/1ps
`include "rqd_defs.vh"
module rqd_request_path #(
  parameter TAG_W = 6
) (
  input  wire         clock,
  input  wire         sys_rst,
  input  wire         wb_cyc_i,
  input  wire         wb_stb_i,
  input  wire         wb_we_i,
  input  wire [7:0]   wb_adr_i,
  input  wire [3:0]   wb_sel_i,
  input  wire [31:0]  wb_dat_i,
  output reg  [31:0]  wb_dat_o,
  output reg          wb_ack_o,
  input  wire         req_port_valid,
  output wire         req_port_ready,
  input  wire [127:0] req_port_data,
  input  wire [3:0]   req_port_dword_keep,
  input  wire         req_port_last_beat,
  input  wire [11:0]  req_port_sideband,
  input  wire [7:0]   cfg_bus_number,
  output reg          tlp_valid,
  input  wire         tlp_ready,
  output reg  [127:0] tlp_data,
  output reg  [3:0]   tlp_keep,
  output reg          tlp_last,
  output reg          tlp_nullify,
  output reg  [2:0]   tlp_addr_offset
);

  localparam S_HEAD = 3'b001;
  localparam S_BODY = 3'b010;
  localparam S_DROP = 3'b100;

  localparam K_MEM  = 3'h0;
  localparam K_IO   = 3'h1;
  localparam K_CFG  = 3'h2;
  localparam K_MSG  = 3'h3;
  localparam K_VMSG = 3'h4;
  localparam K_ATS  = 3'h5;
  localparam K_ATOM = 3'h6;

  ////////////////////////////////////////////////////////////////////////
  // request type decode helpers

  function [2:0] rqd_kind;
    input [3:0] t;
    begin
      case (t)
        `RQD_T_MRD, `RQD_T_MWR, `RQD_T_LRD: rqd_kind = K_MEM;
        `RQD_T_IORD, `RQD_T_IOWR:           rqd_kind = K_IO;
        `RQD_T_FADD, `RQD_T_SWAP, `RQD_T_CAS: rqd_kind = K_ATOM;
        `RQD_T_MSG:                          rqd_kind = K_MSG;
        `RQD_T_VMSG:                         rqd_kind = K_VMSG;
        `RQD_T_ATS:                          rqd_kind = K_ATS;
        default:                             rqd_kind = K_CFG;
      endcase
    end
  endfunction

  function rqd_is_msg;
    input [2:0] k;
    begin
      rqd_is_msg = (k == K_MSG) || (k == K_VMSG) || (k == K_ATS);
    end
  endfunction

  function rqd_has_data;
    input [3:0]  t;
    input [10:0] cnt;
    begin
      case (t)
        `RQD_T_MWR, `RQD_T_IOWR, `RQD_T_CFG0WR, `RQD_T_CFG1WR,
        `RQD_T_FADD, `RQD_T_SWAP, `RQD_T_CAS: rqd_has_data = 1'b1;
        `RQD_T_MSG, `RQD_T_VMSG, `RQD_T_ATS:  rqd_has_data = |cnt;
        default:                               rqd_has_data = 1'b0;
      endcase
    end
  endfunction

  function [4:0] rqd_type_field;
    input [3:0] t;
    input [2:0] route;
    begin
      case (t)
        `RQD_T_LRD:                  rqd_type_field = `RQD_H_LOCK;
        `RQD_T_IORD, `RQD_T_IOWR:    rqd_type_field = `RQD_H_IO;
        `RQD_T_CFG0RD, `RQD_T_CFG0WR: rqd_type_field = `RQD_H_CFG0;
        `RQD_T_CFG1RD, `RQD_T_CFG1WR: rqd_type_field = `RQD_H_CFG1;
        `RQD_T_FADD:                 rqd_type_field = `RQD_H_FADD;
        `RQD_T_SWAP:                 rqd_type_field = `RQD_H_SWAP;
        `RQD_T_CAS:                  rqd_type_field = `RQD_H_CAS;
        `RQD_T_MSG, `RQD_T_VMSG, `RQD_T_ATS:
          rqd_type_field = {`RQD_H_MSG, route};
        default:                     rqd_type_field = `RQD_H_MEM;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // control registers

  reg  [7:0]  ctrl;
  reg  [7:0]  own_devfn;
  reg  [31:0] pkt_count;
  reg  [31:0] err_count;
  reg  [2:0]  state;
  reg         err_sticky;
  reg         keep_fault;
  wire        wb_req;
  wire        wb_wr;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  always @(posedge clock) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      ctrl      <= `RQD_CTRL_RST;
      own_devfn <= 8'h00;
    end else if (wb_wr && wb_sel_i[0]) begin
      if (wb_adr_i == `RQD_A_CTRL) begin
        ctrl <= wb_dat_i[7:0];
      end
      if (wb_adr_i == `RQD_A_IDENT) begin
        own_devfn <= wb_dat_i[7:0];
      end
    end
  end

  // unmapped addresses are acknowledged and read as zero
  always @(posedge clock) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        `RQD_A_CTRL:   wb_dat_o <= {24'h000000, ctrl};
        `RQD_A_IDENT:  wb_dat_o <= {16'h0000, cfg_bus_number, own_devfn};
        `RQD_A_STATUS: wb_dat_o <= {27'h0000000, keep_fault, err_sticky,
                                    state};
        `RQD_A_PKTS:   wb_dat_o <= pkt_count;
        `RQD_A_ERRS:   wb_dat_o <= err_count;
        default:       wb_dat_o <= 32'h00000000;
      endcase
    end else begin
      wb_dat_o <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // header formation from the descriptor beat

  wire [127:0] d;
  wire [3:0]   rtype;
  wire [2:0]   kind;
  wire         is_msg;
  wire         posted;
  wire         has_data;
  wire         addr64;
  wire         four_dw;
  wire [TAG_W-1:0] own_tag;
  reg  [127:0] hdr;
  reg  [15:0]  req_id;
  reg  [7:0]   tag;
  reg  [2:0]   attr;
  reg  [1:0]   at;
  reg          digest;

  assign d        = req_port_data;
  assign rtype    = d[`RQD_F_REQTYPE];
  assign kind     = rqd_kind(rtype);
  assign is_msg   = rqd_is_msg(kind);
  assign posted   = (rtype == `RQD_T_MWR) || is_msg;
  assign has_data = rqd_has_data(rtype, d[`RQD_F_COUNT]);
  assign addr64   = |d[`RQD_F_ADDR_HI];
  assign four_dw  = is_msg || (addr64 && (kind == K_MEM || kind == K_ATOM));

  always @* begin
    // endpoint takes the captured bus number
    if (d[`RQD_B_RID_EN]) begin
      req_id = d[`RQD_F_REQ_ID];
    end else begin
      req_id = {cfg_bus_number, own_devfn};
    end
    if (posted) begin
      tag = d[`RQD_F_TAG];
    end else if (ctrl[`RQD_C_UTAG]) begin
      tag = {2'b00, d[`RQD_F_UTAG]};
    end else begin
      tag = {{(8-TAG_W){1'b0}}, own_tag};
    end
    attr = {d[`RQD_B_IDO] & ctrl[`RQD_C_IDO_EN],
            d[`RQD_B_RO] & ctrl[`RQD_C_RO_EN],
            d[`RQD_B_NS] & ctrl[`RQD_C_NS_EN]};
    if (kind == K_MEM || kind == K_ATOM) begin
      at = d[`RQD_F_AT];
    end else begin
      at = 2'b00;
    end
    digest = d[`RQD_B_ECRC] | ctrl[`RQD_C_ECRC_EN];
    hdr = 128'h0;
    hdr[31:29] = {1'b0, has_data, four_dw};
    hdr[28:24] = rqd_type_field(rtype, d[`RQD_F_ROUTE]);
    hdr[22:20] = d[`RQD_F_TC];
    hdr[18]    = attr[2];
    hdr[15]    = digest;
    hdr[14]    = d[`RQD_B_POISON];
    hdr[13:12] = attr[1:0];
    hdr[11:10] = at;
    // length passes unchecked against payload and size limits
    hdr[9:0]   = d[`RQD_F_LEN];
    hdr[63:48] = req_id;
    hdr[47:40] = tag;
    if (is_msg) begin
      hdr[39:32] = d[`RQD_F_MSG_CODE];
    end else begin
      hdr[39:32] = {req_port_sideband[`RQD_S_TAIL_BE],
                    req_port_sideband[`RQD_S_HEAD_BE]};
    end
    case (kind)
      K_CFG: begin
        hdr[95:64] = {d[`RQD_F_CPL_ID], 4'h0, d[`RQD_F_REG], 2'b00};
      end
      K_VMSG: begin
        hdr[95:64]  = {d[`RQD_F_DEST_ID], 16'h0000};
        hdr[127:96] = d[`RQD_F_VEND_HDR];
      end
      K_ATS: begin
        hdr[95:64]  = d[`RQD_F_ATS_LO];
        hdr[127:96] = d[`RQD_F_ATS_HI];
      end
      K_MSG: begin
        if (d[`RQD_F_MSG_CODE] == `RQD_MC_LTR) begin
          hdr[127:96] = {d[`RQD_F_NOSNOOP], d[`RQD_F_SNOOP]};
        end else if (d[`RQD_F_MSG_CODE] == `RQD_MC_OBFF) begin
          hdr[127:96] = {28'h0000000, d[`RQD_F_OBFF]};
        end else if (d[`RQD_F_ROUTE] == `RQD_ROUTE_ID) begin
          hdr[95:64] = {d[`RQD_F_CPL_ID], 16'h0000};
        end else begin
          hdr[95:64] = 32'h00000000;
        end
      end
      default: begin
        if (four_dw) begin
          hdr[95:64]  = d[`RQD_F_ADDR_HI];
          hdr[127:96] = {d[`RQD_F_ADDR_LO], 2'b00};
        end else begin
          hdr[95:64]  = {d[`RQD_F_ADDR_LO], 2'b00};
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // framing and output stage

  wire can_load;
  wire beat;
  wire head_beat;
  wire abort_now;
  wire keep_ok;
  reg  [2:0] next_state;
  reg        load;
  reg [127:0] next_data;
  reg [3:0]  next_keep;
  reg        next_last;
  reg        next_null;

  assign can_load = ~tlp_valid | tlp_ready;
  // a dropped packet is drained at full rate so the user is not stuck
  assign req_port_ready = (state == S_DROP) ? 1'b1 : can_load;
  assign beat      = req_port_valid & req_port_ready;
  assign head_beat = beat & (state == S_HEAD);
  // valid falling inside a packet is an error
  assign abort_now = (state == S_BODY) & ~req_port_valid & can_load;
  // keep must be a run from lane 0; a short run is only legal on the last beat
  assign keep_ok = req_port_last_beat ?
                   ((req_port_dword_keep & (req_port_dword_keep + 4'h1))
                    == 4'h0) :
                   (req_port_dword_keep == 4'hF);

  rqd_tag_gen #(
    .TAG_W   (TAG_W)
  ) u_tag (
    .clock   (clock),
    .sys_rst (sys_rst),
    .advance (head_beat & ~posted & ~ctrl[`RQD_C_UTAG]),
    .tag     (own_tag)
  );

  always @* begin
    next_state = state;
    load       = 1'b0;
    next_data  = req_port_data;
    next_keep  = req_port_dword_keep;
    next_last  = req_port_last_beat;
    next_null  = err_sticky | req_port_sideband[`RQD_S_DISCONT];
    case (state)
      S_HEAD: begin
        if (beat) begin
          load      = 1'b1;
          next_data = hdr;
          next_keep = four_dw ? 4'hF : 4'h7;
          next_null = req_port_sideband[`RQD_S_DISCONT];
          if (!req_port_last_beat) begin
            next_state = S_BODY;
          end
        end
      end
      S_BODY: begin
        if (beat) begin
          // payload follows the header beat unchanged
          load = 1'b1;
          if (req_port_last_beat) begin
            next_state = S_HEAD;
          end
        end else if (abort_now) begin
          load       = 1'b1;
          next_data  = 128'h0;
          next_keep  = 4'h0;
          next_last  = 1'b1;
          next_null  = 1'b1;
          next_state = S_DROP;
        end
      end
      S_DROP: begin
        if (beat && req_port_last_beat) begin
          next_state = S_HEAD;
        end
      end
      default: begin
        next_state = S_HEAD;
      end
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      state <= S_HEAD;
    end else begin
      state <= next_state;
    end
  end

  // discontinue is sticky for the rest of the packet
  always @(posedge clock) begin
    if (sys_rst) begin
      err_sticky <= 1'b0;
    end else if (beat && req_port_last_beat) begin
      err_sticky <= 1'b0;
    end else if (beat && req_port_sideband[`RQD_S_DISCONT]) begin
      err_sticky <= 1'b1;
    end
  end

  // keep fault is sticky until the control register is written
  always @(posedge clock) begin
    if (sys_rst) begin
      keep_fault <= 1'b0;
    end else if (beat && !keep_ok) begin
      keep_fault <= 1'b1;
    end else if (wb_wr && wb_adr_i == `RQD_A_CTRL) begin
      keep_fault <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      tlp_valid       <= 1'b0;
      tlp_data        <= 128'h0;
      tlp_keep        <= 4'h0;
      tlp_last        <= 1'b0;
      tlp_nullify     <= 1'b0;
      tlp_addr_offset <= 3'h0;
    end else if (load) begin
      tlp_valid   <= 1'b1;
      tlp_data    <= next_data;
      tlp_keep    <= next_keep;
      tlp_last    <= next_last;
      tlp_nullify <= next_null;
      if (head_beat) begin
        if (ctrl[`RQD_C_AALIGN] && !is_msg) begin
          tlp_addr_offset <= req_port_sideband[`RQD_S_OFFSET];
        end else begin
          tlp_addr_offset <= 3'h0;
        end
      end
    end else if (tlp_ready) begin
      tlp_valid <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      pkt_count <= 32'h00000000;
      err_count <= 32'h00000000;
    end else if (load && next_last) begin
      pkt_count <= pkt_count + 32'h00000001;
      if (next_null) begin
        err_count <= err_count + 32'h00000001;
      end
    end
  end

endmodule

// *** rqd_defs.vh ***
// constants for the requester request descriptor path
//
// Notes on behaviour
// - descriptor address type goes into header AT for memory and atomics
// - dword count is sent as given, never checked against payload
// - request type code at 78:75 selects the header format and type
// - endpoint uses captured bus number, root port uses descriptor id
// - posted use descriptor tag, non-posted only with user tag option
// - attribute bits are cleared when not enabled for the function
// - bit 127 forces a digest onto the request even with ecrc off
// - ltr messages carry snoop and no-snoop latency in the header
// - every message takes message code and routing into the header
// - id routed vendor messages carry destination id, dword 3 copied
// - ats messages copy descriptor 63:0 into header dwords two, three
// - valid dropped inside a packet nullifies the request
// - ready may drop any cycle, user holds signals and marks last
`ifndef RQD_DEFS_VH
`define RQD_DEFS_VH

////////////////////////////////////////////////////////////////////////////
// descriptor fields
`define RQD_F_AT        1:0
`define RQD_F_ADDR_LO   31:2
`define RQD_F_ADDR_HI   63:32
`define RQD_F_REG       11:2
`define RQD_F_COUNT     74:64
`define RQD_F_LEN       73:64
`define RQD_F_REQTYPE   78:75
`define RQD_B_POISON    79
`define RQD_F_REQ_ID    95:80
`define RQD_F_TAG       103:96
`define RQD_F_UTAG      101:96
`define RQD_F_CPL_ID    119:104
`define RQD_F_MSG_CODE  111:104
`define RQD_F_ROUTE     114:112
`define RQD_B_RID_EN    120
`define RQD_F_TC        123:121
`define RQD_B_NS        124
`define RQD_B_RO        125
`define RQD_B_IDO       126
`define RQD_B_ECRC      127
`define RQD_F_SNOOP     15:0
`define RQD_F_NOSNOOP   31:16
`define RQD_F_OBFF      35:32
`define RQD_F_DEST_ID   15:0
`define RQD_F_VEND_HDR  63:32
`define RQD_F_ATS_LO    31:0
`define RQD_F_ATS_HI    63:32

// sideband layout
`define RQD_S_HEAD_BE   3:0
`define RQD_S_TAIL_BE   7:4
`define RQD_S_OFFSET    10:8
`define RQD_S_DISCONT   11

// request type codes
`define RQD_T_MRD       4'h0
`define RQD_T_MWR       4'h1
`define RQD_T_IORD      4'h2
`define RQD_T_IOWR      4'h3
`define RQD_T_FADD      4'h4
`define RQD_T_SWAP      4'h5
`define RQD_T_CAS       4'h6
`define RQD_T_LRD       4'h7
`define RQD_T_CFG0RD    4'h8
`define RQD_T_CFG0WR    4'h9
`define RQD_T_CFG1RD    4'hA
`define RQD_T_CFG1WR    4'hB
`define RQD_T_MSG       4'hC
`define RQD_T_VMSG      4'hD
`define RQD_T_ATS       4'hE

// header type field values
`define RQD_H_MEM       5'h00
`define RQD_H_LOCK      5'h01
`define RQD_H_IO        5'h02
`define RQD_H_CFG0      5'h04
`define RQD_H_CFG1      5'h05
`define RQD_H_FADD      5'h0C
`define RQD_H_SWAP      5'h0D
`define RQD_H_CAS       5'h0E
`define RQD_H_MSG       2'h2
`define RQD_MC_LTR      8'h10
`define RQD_MC_OBFF     8'h12
`define RQD_ROUTE_ID    3'h2

// register map, byte addresses
`define RQD_A_CTRL      8'h00
`define RQD_A_IDENT     8'h04
`define RQD_A_STATUS    8'h08
`define RQD_A_PKTS      8'h0C
`define RQD_A_ERRS      8'h10
`define RQD_CTRL_RST    8'h00
`define RQD_C_UTAG      0
`define RQD_C_AALIGN    1
`define RQD_C_RO_EN     2
`define RQD_C_NS_EN     3
`define RQD_C_IDO_EN    4
`define RQD_C_ECRC_EN   5

`endif

// *** rqd_tag_gen.v ***
// tag source for non-posted requests when tags are managed inside
`timescale 1ns/1ps
module rqd_tag_gen #(
  parameter TAG_W = 6
) (
  input  wire             clock,
  input  wire             sys_rst,
  input  wire             advance,
  output reg  [TAG_W-1:0] tag
);

  // simple rotation; outstanding tag tracking lives with completions
  always @(posedge clock) begin
    if (sys_rst) begin
      tag <= {TAG_W{1'b0}};
    end else if (advance) begin
      tag <= tag + {{(TAG_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// *** rqd_sva.sv ***
// checker: request header fields against the descriptor that caused them
`timescale 1ns/1ps
module rqd_sva (
  input wire         clock,
  input wire         sys_rst,
  input wire         wb_we_i,
  input wire [7:0]   wb_adr_i,
  input wire [31:0]  wb_dat_i,
  input wire         wb_ack_o,
  input wire         req_port_valid,
  input wire         req_port_ready,
  input wire [127:0] req_port_data,
  input wire [3:0]   req_port_dword_keep,
  input wire         req_port_last_beat,
  input wire [7:0]   cfg_bus_number,
  input wire         tlp_valid,
  input wire         tlp_ready,
  input wire [127:0] tlp_data,
  input wire [3:0]   tlp_keep,
  input wire         tlp_last,
  input wire         tlp_nullify
);
  reg        in_pkt;
  reg        dropping;
  reg [5:0]  ctrl;
  wire       take = req_port_valid && req_port_ready;
  wire       head = take && !in_pkt;
  wire [3:0] rt   = req_port_data[78:75];
  wire       mem  = rt < 4'h2 || (rt > 4'h3 && rt < 4'h8);
  wire       gap  = in_pkt && !dropping && !req_port_valid
                    && (!tlp_valid || tlp_ready);
  ////////////////////////////////////////////////////////////////////////
  // ctrl shadow takes each write at its acknowledge
  always @(posedge clock) begin
    if (sys_rst) begin
      in_pkt   <= 1'b0;
      dropping <= 1'b0;
      ctrl     <= 6'h00;
    end else begin
      if (take)
        in_pkt <= !req_port_last_beat;
      if (gap)
        dropping <= 1'b1;
      else if (take && req_port_last_beat)
        dropping <= 1'b0;
      if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00)
        ctrl <= wb_dat_i[5:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_AT: assert property (head && mem |=>
    tlp_valid && tlp_data[11:10] == $past(req_port_data[1:0]))
    else $error("address type not copied");
  AST_LEN: assert property (head && rt < 4'hC |=>
    tlp_data[9:0] == $past(req_port_data[73:64]))
    else $error("length differs from dword count");
  AST_TD: assert property (head && req_port_data[127] |=> tlp_data[15])
    else $error("forced digest missing");
  AST_ATTR: assert property (head |=>
    tlp_data[13:12] == ($past(req_port_data[125:124]) & {ctrl[2], ctrl[3]})
    && tlp_data[18] == ($past(req_port_data[126]) & ctrl[4]))
    else $error("attribute not masked by enables");
  AST_TAG: assert property (head && rt == 4'h1 |=>
    tlp_data[45:40] == $past(req_port_data[101:96]))
    else $error("posted tag not taken from descriptor");
  AST_RID: assert property (head && !req_port_data[120] |=>
    tlp_data[63:56] == $past(cfg_bus_number))
    else $error("captured bus number not used");
  AST_MSG: assert property (head && rt > 4'hB |=>
    tlp_data[39:32] == $past(req_port_data[111:104])
    && tlp_data[26:24] == $past(req_port_data[114:112]))
    else $error("message code or routing wrong");
  AST_HOLD: assert property (tlp_valid && !tlp_ready |=>
    tlp_valid && $stable(tlp_data) && $stable(tlp_keep) && $stable(tlp_last))
    else $error("output beat changed while stalled");
  AST_NULL: assert property (gap |=>
    tlp_valid && tlp_last && tlp_nullify && tlp_keep == 4'h0)
    else $error("valid gap did not nullify");
  AST_PAY: assert property (take && in_pkt && !dropping |=>
    tlp_valid && tlp_data == $past(req_port_data)
    && tlp_keep == $past(req_port_dword_keep)
    && tlp_last == $past(req_port_last_beat))
    else $error("payload beat altered");
  COV_MULTI: cover property (head && !req_port_last_beat);
  COV_GAP: cover property (gap);
  COV_ATS: cover property (head && rt == 4'hE);
endmodule

bind rqd_request_path rqd_sva u_sva (
  .clock(clock), .sys_rst(sys_rst), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .req_port_valid(req_port_valid), .req_port_ready(req_port_ready),
  .req_port_data(req_port_data), .req_port_dword_keep(req_port_dword_keep),
  .req_port_last_beat(req_port_last_beat), .cfg_bus_number(cfg_bus_number),
  .tlp_valid(tlp_valid), .tlp_ready(tlp_ready), .tlp_data(tlp_data),
  .tlp_keep(tlp_keep), .tlp_last(tlp_last), .tlp_nullify(tlp_nullify)
);

// *** rqd_user_app.sv ***
// user application model driving the request stream
`timescale 1ns/1ps
module rqd_user_app (
  input  wire         clock,
  input  wire         req_port_ready,
  output reg          req_port_valid,
  output reg  [127:0] req_port_data,
  output reg  [3:0]   req_port_dword_keep,
  output reg          req_port_last_beat,
  output reg  [11:0]  req_port_sideband
);
  initial begin
    req_port_valid = 1'b0;
    req_port_data = 128'h0;
    req_port_dword_keep = 4'h0;
    req_port_last_beat = 1'b0;
    req_port_sideband = 12'h000;
  end
  // call just after an edge; returns at the edge that took the beat
  task beat(input [127:0] d, input [3:0] k, input l, input [11:0] s);
    begin
      req_port_valid <= 1'b1;
      req_port_data <= d;
      req_port_dword_keep <= k;
      req_port_last_beat <= l;
      req_port_sideband <= s;
      @(posedge clock);
      while (req_port_ready !== 1'b1) @(posedge clock);
    end
  endtask
  // released data, keep and last lines change so a stale beat cannot pass for a real one
  task idle;
    begin
      req_port_valid <= 1'b0;
      req_port_data <= ~req_port_data;
      req_port_dword_keep <= ~req_port_dword_keep;
      req_port_last_beat <= ~req_port_last_beat;
      @(posedge clock);
    end
  endtask
endmodule

// *** rqd_testbench.sv ***
// self-checking bench for the requester request path
`timescale 1ns/1ps
module testbench;
  localparam [95:0]  TT = 96'h45_05_44_04_01_4E_4D_4C_42_02_40_00;
  localparam [23:0]  HI = 24'h0A_7A_FA;
  localparam [17:0]  CT = {6'h20, 6'h1E, 6'h00};
  localparam [95:0]  DW = {32'h60508006, 32'h60543006, 32'h60508006};
  localparam [15:0]  MT = 16'hCEDC;
  localparam [63:0]  MI = 64'h0412_0201_027E_0410;
  localparam [255:0] ML = {64'h0000000F_00000000, 64'h89ABCDEF_01234567,
                           64'hCAFEF00D_00000102, 64'h00000000_BEEF1234};
  localparam [127:0] E3 = 128'h0000000F_89ABCDEF_CAFEF00D_BEEF1234;
  localparam [127:0] E2 = 128'h00000000_01234567_01020000_00000000;
  localparam [127:0] M2 = 128'hFFFFFFFF_FFFFFFFF_FFFF0000_00000000;
  localparam [31:0]  MH = 32'h34_32_32_34;
  reg          clock;
  reg          sys_rst;
  reg          wb_cyc_i;
  reg          wb_stb_i;
  reg          wb_we_i;
  reg  [7:0]   wb_adr_i;
  reg  [3:0]   wb_sel_i;
  reg  [31:0]  wb_dat_i;
  wire [31:0]  wb_dat_o;
  wire         wb_ack_o;
  wire         req_port_valid;
  wire         req_port_ready;
  wire [127:0] req_port_data;
  wire [3:0]   req_port_dword_keep;
  wire         req_port_last_beat;
  wire [11:0]  req_port_sideband;
  reg  [7:0]   cfg_bus_number;
  wire         tlp_valid;
  reg          tlp_ready;
  wire [127:0] tlp_data;
  wire [3:0]   tlp_keep;
  wire         tlp_last;
  wire         tlp_nullify;
  integer      n_fail;
  integer      n_compared;
  integer      i;
  reg  [133:0] seen[$];
  reg  [133:0] b;
  reg  [31:0]  rd;
  rqd_request_path #(.TAG_W(6)) dut (
    .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .req_port_valid(req_port_valid),
    .req_port_ready(req_port_ready), .req_port_data(req_port_data),
    .req_port_dword_keep(req_port_dword_keep),
    .req_port_last_beat(req_port_last_beat),
    .req_port_sideband(req_port_sideband), .cfg_bus_number(cfg_bus_number),
    .tlp_valid(tlp_valid), .tlp_ready(tlp_ready), .tlp_data(tlp_data),
    .tlp_keep(tlp_keep), .tlp_last(tlp_last), .tlp_nullify(tlp_nullify),
    .tlp_addr_offset()
  );
  rqd_user_app usr (
    .clock(clock), .req_port_ready(req_port_ready),
    .req_port_valid(req_port_valid), .req_port_data(req_port_data),
    .req_port_dword_keep(req_port_dword_keep),
    .req_port_last_beat(req_port_last_beat),
    .req_port_sideband(req_port_sideband)
  );
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // far side stalls every other cycle so an output beat offered in a stalled cycle must hold
  always @(posedge clock) tlp_ready <= ~tlp_ready;
  always @(posedge clock) begin
    if (tlp_valid === 1'b1 && tlp_ready === 1'b1)
      seen.push_back({tlp_nullify, tlp_last, tlp_keep, tlp_data});
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input [133:0] e, input [133:0] g);
    begin
      n_compared = n_compared + 1;
      if (e !== g) begin
        n_fail = n_fail + 1;
        $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
    end
  endtask
  task wb(input we, input [7:0] a, input [31:0] d, output [31:0] q);
    integer n;
    begin
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      @(posedge clock);
      while (wb_ack_o !== 1'b1 && n < 20) begin
        @(posedge clock);
        n = n + 1;
      end
      chk("bus ack", 1, wb_ack_o);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clock);
    end
  endtask
  task get(output [133:0] g);
    integer n;
    begin
      n = 0;
      while (seen.size() == 0 && n < 100) begin
        @(posedge clock);
        n = n + 1;
      end
      chk("beat present", 1, seen.size() != 0);
      g = (seen.size() != 0) ? seen.pop_front() : 134'h0;
    end
  endtask
  function [127:0] dsc(input [7:0] hi, input [15:0] mid, input [7:0] tag,
                       input [3:0] rt, input [10:0] cnt, input [63:0] lo);
    dsc = {hi, mid, tag, 16'h0000, 1'b0, rt, cnt, lo};
  endfunction
  task wrap_up;
    begin
      if (n_fail == 0 && n_compared > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    n_fail = n_fail + 1;
    wrap_up;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    n_fail = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    tlp_ready = 1'b1;
    cfg_bus_number = 8'h5A;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    wb(1'b0, 8'h00, 32'h0, rd);
    chk("ctrl reset", 32'h0, rd);
    wb(1'b1, 8'h04, 32'hFFFF003C, rd);
    wb(1'b0, 8'h04, 32'h0, rd);
    chk("ident", 32'h5A3C, rd);
    wb(1'b1, 8'h14, 32'hFF, rd);
    wb(1'b0, 8'h14, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    for (i = 0; i < 12; i = i + 1) begin
      usr.beat(dsc(8'h00, 16'h0, 8'h00, i[3:0], 11'd1, 64'h1000), 4'hF,
               1'b1, 12'h000);
      usr.idle;
      get(b);
      chk("head type", {TT[8*i+:8], 10'd1, 6'h17},
          {b[31:24], b[9:0], b[133:128]});
    end
    for (i = 0; i < 3; i = i + 1) begin
      wb(1'b1, 8'h00, {26'h0, CT[6*i+:6]}, rd);
      usr.beat(dsc(HI[8*i+:8], 16'h0, 8'h2A, 4'h1, 11'd6,
                   64'h1_2345_6780 | i[1:0]), 4'hF, 1'b0, 12'h5FF);
      usr.beat({4{32'h11110000 + i}}, 4'hF, 1'b0, 12'h0FF);
      usr.beat({4{32'h22220000 + i}}, 4'h3, 1'b1, 12'h0FF);
      usr.idle;
      get(b);
      chk("mwr header", {6'h0F, 32'h23456780, 32'h1, 32'h5A3C2AFF,
          DW[32*i+:32] | (i[1:0] << 10)}, b);
      get(b);
      chk("payload", {6'h0F, {4{32'h11110000 + i}}}, b);
      get(b);
      chk("last payload", {6'h13, {4{32'h22220000 + i}}}, b);
      chk("offset", 5 * CT[6*i+1], dut.tlp_addr_offset);
    end
    usr.beat(dsc(8'h00, 16'h0, 8'h01, 4'h1, 11'd4, 64'h2000), 4'hF, 1'b0,
             12'h0FF);
    repeat (3) usr.idle;
    usr.beat(128'h0, 4'hF, 1'b1, 12'h0FF);
    usr.idle;
    get(b);
    get(b);
    chk("nullify beat", 6'h30, b[133:128]);
    for (i = 0; i < 4; i = i + 1) begin
      usr.beat(dsc(8'h00, MI[16*i+:16], 8'h00, MT[4*i+:4], 11'd0,
                   ML[64*i+:64]), 4'hF, 1'b1, 12'h000);
      usr.idle;
      get(b);
      chk("message", {MH[8*i+:8], MI[16*i+:8], E3[32*i+:32], E2[32*i+:32],
          4'hF}, {b[31:24], b[39:32], b[127:96], b[95:64] & M2[32*i+:32],
          b[131:128]});
    end
    wb(1'b0, 8'h0C, 32'h0, rd);
    chk("packets sent", 32'd20, rd);
    wb(1'b0, 8'h10, 32'h0, rd);
    chk("nullified", 32'd1, rd);
    wrap_up;
  end
endmodule
